// File: adc_result_spi_readback_tb.sv
`timescale 1ns/1ps
module adc_result_spi_readback_tb;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  ars_pkg::ars_mode_t mode = ars_pkg::ARS_SAMPLE;
  logic               conv_start = 1'b0;
  logic               res_valid = 1'b0;
  logic [23:0]        res_data = 24'h000000;
  logic               res_ready, conv_req, result_lost, sclk, cs_n, sdo, sdo_oe;
  logic [23:0]        w;
  int                 n_errors = 0, tests_run = 0, n_req = 0, n_lost = 0, cyc = 0;
  ars_readback #(.TIMER_CYCLES(16'h0004)) uut (.clk(clk), .resetn(resetn), .mode(mode),
    .conv_start(conv_start), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .conv_req(conv_req), .result_lost(result_lost), .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe));
  ars_host host (.sclk(sclk), .cs_n(cs_n), .sdo(sdo));
  // clock generator
  always #5 clk = ~clk;
  // pulse counters and hang limit
  always @(posedge clk)
  begin
    n_req += (conv_req === 1'b1);
    n_lost += (result_lost === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_count(input int got, input int exp, input string what);
    tests_run++;
    if (got != exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_count
  task automatic chk_flag(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_flag
  // hold valid and data until ready is seen at a rising edge
  task automatic push(input logic [23:0] d);
    @(negedge clk) res_valid = 1'b1;
    res_data = d;
    @(posedge clk);
    while (res_ready !== 1'b1) @(posedge clk);
    @(negedge clk) res_valid = 1'b0;
  endtask : push
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_sample;
    @(negedge clk) n_req = 0;
    conv_start = 1'b1;
    @(negedge clk) conv_start = 1'b0;
    repeat (3) @(negedge clk);
    chk_count(n_req, 1, "start pulse");
    push(24'h7fa5c3);
    host.read_frame(16, w);
    chk(w, 24'h00a5c3, "sample word");
    chk_flag(sdo_oe, 1'b0, "released");
    $display("test sample done");
  endtask : t_sample
  task automatic t_avg;
    @(negedge clk) mode = ars_pkg::ARS_AVERAGE;
    push(24'h9b3e71);
    fork
      host.read_frame(24, w);
      begin
        #500;
        chk_flag(sdo_oe, 1'b1, "driven while selected");
      end
    join
    chk(w, 24'h9b3e71, "average word");
    $display("test average done");
  endtask : t_avg
  task automatic t_burst;
    @(negedge clk) mode = ars_pkg::ARS_BURST;
    n_req = 0;
    conv_start = 1'b1;
    @(negedge clk) conv_start = 1'b0;
    repeat (39) @(negedge clk);
    chk_count(n_req, 9, "timer ticks");
    n_lost = 0;
    push(24'hc01d5e);
    push(24'h3a6b90);
    chk_flag(res_ready, 1'b0, "full refuses");
    host.read_frame(24, w);
    chk(w, 24'hc01d5e, "burst first");
    host.read_frame(24, w);
    chk(w, 24'h3a6b90, "burst second");
    chk_count(n_lost, 0, "no loss");
    $display("test burst done");
  endtask : t_burst
  task automatic t_auto;
    @(negedge clk) mode = ars_pkg::ARS_AUTO;
    n_lost = 0;
    push(24'h5e7a1c);
    host.read_frame(16, w);
    chk(w, 24'h007a1c, "auto word");
    chk_count(n_lost, 0, "auto no loss");
    $display("test auto done");
  endtask : t_auto
  task automatic t_lost;
    @(negedge clk) mode = ars_pkg::ARS_SAMPLE;
    n_lost = 0;
    push(24'h001111);
    push(24'h002222);
    push(24'h003333);
    repeat (2) @(negedge clk);
    chk_count(n_lost, 1, "lost pulse");
    host.read_frame(16, w);
    chk(w, 24'h002222, "kept word");
    host.read_frame(16, w);
    chk(w, 24'h003333, "newest word");
    $display("test lost done");
  endtask : t_lost
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_sample();
    t_avg();
    t_burst();
    t_auto();
    t_lost();
    report_and_stop();
  end
endmodule : adc_result_spi_readback_tb

// File: ars_consts.svh
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH
// packet lengths in bits per mode
`define ARS_BITS_SAMPLE   6'h10
`define ARS_BITS_AVG      6'h18
`define ARS_BITS_BURST    6'h18
`define ARS_BITS_AUTO     6'h10
// result word width carried through the buffer
`define ARS_WORD_W        24
// internal timer period in clock cycles (default pacing)
`define ARS_TIMER_DEF     16'h0064
`endif

// File: ars_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// host link controller model
// ----------------------------------------
module ars_host (
  output logic      sclk,
  output logic      cs_n,
  input  wire logic sdo
);
  // link idles deselected with clock low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // one frame, msb first; 125 ns period covers rising capture
  // rising-edge capture, so the fastest clock periods are never used
  // the odd lead-in keeps every sclk edge and the deselect off the system clock edges
  task automatic read_frame(input int n, output logic [23:0] w);
    w = 24'h000000;
    cs_n = 1'b0;
    #101;
    repeat (n)
    begin
      #62.5 sclk = 1'b1;
      w = {w[22:0], sdo};
      #62.5 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    #100;
  endtask : read_frame
endmodule : ars_host

// File: ars_pkg.sv
package ars_pkg;
  // operating modes of the converter
  typedef enum logic [1:0]
  {
    ARS_SAMPLE,
    ARS_AVERAGE,
    ARS_BURST,
    ARS_AUTO
  } ars_mode_t;
endpackage : ars_pkg

// File: ars_readback.sv
`timescale 1ns/1ps
`include "ars_consts.svh"

// How it works
// - timer paces sampling in burst/autonomous modes
// - packets are 16 bits sample, 24 averaging
// - mode 0: clock idles low, rising sampled
// - msb driven right after chip select falls
module ars_readback #(
  parameter logic [15:0] TIMER_CYCLES = `ARS_TIMER_DEF
)(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire ars_pkg::ars_mode_t      mode,
  input  wire logic                    conv_start,
  input  wire logic                    res_valid,
  output logic                         res_ready,
  input  wire logic [`ARS_WORD_W-1:0]  res_data,
  output logic                         conv_req,
  output logic                         result_lost,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  output logic                         sdo,
  output logic                         sdo_oe
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sclk_s_r;
  logic [1:0] cs_s_r;
  logic       sclk_d_r;
  logic       cs_d_r;

  // two flops per pin, then a delay stage for edge finding
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      sclk_s_r <= 2'h0;
      cs_s_r   <= 2'h3;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end
    else
    begin
      sclk_s_r <= {sclk_s_r[0], sclk};
      cs_s_r   <= {cs_s_r[0], cs_n};
      sclk_d_r <= sclk_s_r[1];
      cs_d_r   <= cs_s_r[1];
    end

  // edge decode, mode 0 only
  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire cs_fall   = ~cs_s_r[1] & cs_d_r;
  wire cs_rise   = cs_s_r[1] & ~cs_d_r;
  wire cs_act    = ~cs_s_r[1];

  // ----------------------------------------
  // packet length per mode
  // ----------------------------------------
  function automatic logic [5:0] pkt_bits(input ars_pkg::ars_mode_t m);
    unique case (m)
      ars_pkg::ARS_SAMPLE:  pkt_bits = `ARS_BITS_SAMPLE;
      ars_pkg::ARS_AVERAGE: pkt_bits = `ARS_BITS_AVG;
      ars_pkg::ARS_BURST:   pkt_bits = `ARS_BITS_BURST;
      ars_pkg::ARS_AUTO:    pkt_bits = `ARS_BITS_AUTO;
    endcase
  endfunction : pkt_bits

  wire       timed = (mode == ars_pkg::ARS_BURST) || (mode == ars_pkg::ARS_AUTO);
  wire [5:0] nbits = pkt_bits(mode); // always whole bytes

  // ----------------------------------------
  // internal timer and conversion request
  // ----------------------------------------
  logic [15:0] tmr_r;
  wire         tmr_hit = (tmr_r == 16'h0000);

  // timer free-runs in timed modes; host start ignored there
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      tmr_r <= 16'h0000;
    else if (!timed || tmr_hit)
      tmr_r <= TIMER_CYCLES - 16'h0001;
    else
      tmr_r <= tmr_r - 16'h0001;

  // pulse toward the converter core
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      conv_req <= 1'b0;
    else
      conv_req <= timed ? tmr_hit : conv_start;

  // ----------------------------------------
  // two-entry result buffer
  // ----------------------------------------
  logic [`ARS_WORD_W-1:0] buf_r [2];
  logic                   wp_r;
  logic                   rp_r;
  logic [1:0]             cnt_r;
  logic                   load;
  logic [`ARS_WORD_W-1:0] sh_r;
  logic [5:0]             left_r;
  logic                   busy_r;

  wire buf_empty = (cnt_r == 2'h0);
  wire push      = res_valid & res_ready;
  // untimed modes: a new result into a full buffer drops the oldest;
  // a word leaving for the shifter in that cycle is not lost, so wait
  wire drop      = ~timed & res_valid & (cnt_r == 2'h2) & ~load;
  assign res_ready = (cnt_r != 2'h2) | drop;
  assign load      = cs_fall & ~buf_empty;

  // pointers and fill count
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ (load | drop);
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, load | drop};
    end

  // storage
  always_ff @(posedge clk)
    if (push)
      buf_r[wp_r] <= res_data;

  // lost flag: one-cycle pulse when an unread result is discarded
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      result_lost <= 1'b0;
    else
      result_lost <= drop;

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  // left-align the word so the msb of the packet sits on top
  wire [`ARS_WORD_W-1:0] aligned = (nbits == 6'h10) ?
                                   {buf_r[rp_r][15:0], 8'h00} : buf_r[rp_r];

  // load on cs fall, shift on sclk fall, stop after nbits rises
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      sh_r   <= '0;
      left_r <= 6'h00;
      busy_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      busy_r <= 1'b0;
      left_r <= 6'h00;
    end
    else if (load)
    begin
      sh_r   <= aligned; // msb ready before first clock
      left_r <= nbits;
      busy_r <= 1'b1;
    end
    else if (busy_r && sclk_rise && left_r != 6'h00)
      left_r <= left_r - 6'h01;
    else if (busy_r && sclk_fall && left_r != 6'h00)
      sh_r <= {sh_r[`ARS_WORD_W-2:0], 1'b0};

  // drive while selected; zeros after the packet or with no data
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sdo    <= busy_r & (left_r != 6'h00) & sh_r[`ARS_WORD_W-1];
      sdo_oe <= cs_act;
    end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_msb_after_cs: assert property (@(posedge clk) disable iff (!resetn)
    load |=> ##1 (sdo == sh_r[`ARS_WORD_W-1]))
    else $error("msb not driven after select");
  a_oe_follows_cs: assert property (@(posedge clk) disable iff (!resetn)
    cs_act |=> sdo_oe)
    else $error("output not enabled while selected");
  a_len_loaded: assert property (@(posedge clk) disable iff (!resetn)
    load |=> (left_r == nbits && left_r[2:0] == 3'h0))
    else $error("packet length not whole bytes");
  a_len_mode: assert property (@(posedge clk) disable iff (!resetn)
    (mode == ars_pkg::ARS_AVERAGE) |-> (nbits == 6'h18))
    else $error("averaging packet not 24 bits");
  a_len_sample: assert property (@(posedge clk) disable iff (!resetn)
    (mode == ars_pkg::ARS_SAMPLE) |-> (nbits == 6'h10))
    else $error("sample packet not 16 bits");
  a_timer_pace: assert property (@(posedge clk) disable iff (!resetn)
    (timed && tmr_hit && $stable(mode)) |=> conv_req)
    else $error("timer tick gave no conversion");
  a_no_drop_timed: assert property (@(posedge clk) disable iff (!resetn)
    timed |-> !drop)
    else $error("result dropped in timed mode");
  a_shift_rise: assert property (@(posedge clk) disable iff (!resetn)
    (busy_r && !cs_rise && !load && sclk_rise && left_r != 6'h00) |=> (left_r == $past(left_r) - 6'h01))
    else $error("rising edge not counted");
  // one falling link edge moves the next bit to the top
  sequence s_fall_step;
    busy_r && !cs_rise && !load && sclk_fall && (left_r != 6'h00);
  endsequence
  a_shift_fall: assert property (@(posedge clk) disable iff (!resetn)
    s_fall_step |=> (sh_r[`ARS_WORD_W-1:1] == $past(sh_r[`ARS_WORD_W-2:0])))
    else $error("falling edge did not shift");
  // deselect ends the packet at once
  a_stop_deselect: assert property (@(posedge clk) disable iff (!resetn)
    cs_rise |=> (!busy_r && left_r == 6'h00))
    else $error("packet not ended by deselect");
  // every discarded word is flagged
  a_lost_on_drop: assert property (@(posedge clk) disable iff (!resetn)
    drop |=> result_lost)
    else $error("dropped result not flagged");
endmodule : ars_readback
